/* File: iosd_pkg.sv */
// Purpose: constants and carriers for the I/O space register decoder
// Assumes: 8-bit registers, 64-location short I/O window, 9-bit data space
// Notes: masks give the bits that each location really implements
`default_nettype none

package iosd_pkg;

  localparam int         IOSD_IO_LOCS   = 64;
  localparam int         IOSD_NPORT     = 3;
  localparam int         IOSD_NFLAG     = 4;
  localparam logic [5:0] IOSD_BIT_LIMIT = 6'h20;
  localparam logic [8:0] IOSD_DATA_BASE = 9'h020;
  localparam logic [8:0] IOSD_EXT_BASE  = 9'h060;
  localparam logic [8:0] IOSD_EXT_TOP   = 9'h1FF;

  localparam logic [5:0] IOSD_O_PORT_B_INPUT_LEVELS      = 6'h03;
  localparam logic [5:0] IOSD_O_PORT_B_DIRECTION         = 6'h04;
  localparam logic [5:0] IOSD_O_PORT_B_OUTPUT            = 6'h05;
  localparam logic [5:0] IOSD_O_PORT_C_INPUT_LEVELS      = 6'h06;
  localparam logic [5:0] IOSD_O_PORT_C_DIRECTION         = 6'h07;
  localparam logic [5:0] IOSD_O_PORT_C_OUTPUT            = 6'h08;
  localparam logic [5:0] IOSD_O_PORT_D_INPUT_LEVELS      = 6'h09;
  localparam logic [5:0] IOSD_O_PORT_D_DIRECTION         = 6'h0A;
  localparam logic [5:0] IOSD_O_PORT_D_OUTPUT            = 6'h0B;
  localparam logic [5:0] IOSD_O_TIMER0_FLAGS             = 6'h15;
  localparam logic [5:0] IOSD_O_TIMER1_FLAGS             = 6'h16;
  localparam logic [5:0] IOSD_O_EXT_IRQ_FLAGS            = 6'h1C;
  localparam logic [5:0] IOSD_O_EXT_IRQ_MASK             = 6'h1D;
  localparam logic [5:0] IOSD_O_GENERAL_SCRATCH_0        = 6'h1E;
  localparam logic [5:0] IOSD_O_EEPROM_CONTROL           = 6'h1F;
  localparam logic [5:0] IOSD_O_EEPROM_DATA              = 6'h20;
  localparam logic [5:0] IOSD_O_EEPROM_ADDR_LOW          = 6'h21;
  localparam logic [5:0] IOSD_O_EEPROM_ADDR_HIGH         = 6'h22;
  localparam logic [5:0] IOSD_O_TIMER_PRESCALER_CONTROL  = 6'h23;
  localparam logic [5:0] IOSD_O_TIMER0_CONTROL_A         = 6'h24;
  localparam logic [5:0] IOSD_O_TIMER0_CONTROL_B         = 6'h25;
  localparam logic [5:0] IOSD_O_TIMER0_COUNT             = 6'h26;
  localparam logic [5:0] IOSD_O_TIMER0_COMPARE_A         = 6'h27;
  localparam logic [5:0] IOSD_O_TIMER0_COMPARE_B         = 6'h28;
  localparam logic [5:0] IOSD_O_PLL_CONTROL_STATUS       = 6'h29;
  localparam logic [5:0] IOSD_O_GENERAL_SCRATCH_1        = 6'h2A;
  localparam logic [5:0] IOSD_O_GENERAL_SCRATCH_2        = 6'h2B;
  localparam logic [5:0] IOSD_O_SERIAL_PERIPH_CONTROL    = 6'h2C;
  localparam logic [5:0] IOSD_O_SERIAL_PERIPH_STATUS     = 6'h2D;
  localparam logic [5:0] IOSD_O_SERIAL_PERIPH_DATA       = 6'h2E;
  localparam logic [5:0] IOSD_O_COMPARATOR_CTRL_STATUS   = 6'h30;
  localparam logic [5:0] IOSD_O_DEBUG_LINK_DATA          = 6'h31;
  localparam logic [5:0] IOSD_O_SLEEP_CONTROL            = 6'h33;
  localparam logic [5:0] IOSD_O_RESET_CAUSE_FLAGS        = 6'h34;
  localparam logic [5:0] IOSD_O_VECTOR_SELECT_CONTROL    = 6'h35;
  localparam logic [5:0] IOSD_O_SELF_PROGRAM_CONTROL     = 6'h37;

  localparam logic [7:0] IOSD_M_FULL        = 8'hFF;
  localparam logic [7:0] IOSD_M_PORT_C      = 8'hF7;
  localparam logic [7:0] IOSD_M_EEPROM_CTRL = 8'h3F;
  localparam logic [7:0] IOSD_M_PRESCALER   = 8'h83;
  localparam logic [7:0] IOSD_M_T0_CTRL_A   = 8'hF3;
  localparam logic [7:0] IOSD_M_PLL_RW      = 8'h1E;
  localparam logic [7:0] IOSD_M_SPI_STAT_RW = 8'h01;
  localparam logic [7:0] IOSD_M_CMP_RW      = 8'hCF;
  localparam logic [7:0] IOSD_M_CMP_W1C     = 8'h10;
  localparam logic [7:0] IOSD_M_SLEEP       = 8'h0F;
  localparam logic [7:0] IOSD_M_RST_CAUSE   = 8'h2F;
  localparam logic [7:0] IOSD_M_VEC_SEL     = 8'h03;
  localparam logic [7:0] IOSD_M_T0_FLAGS    = 8'h07;
  localparam logic [7:0] IOSD_M_T1_FLAGS    = 8'h2F;

  typedef enum logic [3:0] {
    IOSD_OP_NONE              = 4'h0,
    IOSD_IO_READ              = 4'h1,
    IOSD_IO_WRITE             = 4'h2,
    IOSD_IO_BIT_SET_OP        = 4'h3,
    IOSD_IO_BIT_CLEAR_OP      = 4'h4,
    IOSD_SKIP_IF_IO_BIT_SET   = 4'h5,
    IOSD_SKIP_IF_IO_BIT_CLEAR = 4'h6,
    IOSD_MEM_READ             = 4'h7,
    IOSD_MEM_WRITE            = 4'h8
  } iosd_op_t;

  typedef struct packed {
    iosd_op_t   op;
    logic [5:0] io_addr;
    logic [8:0] mem_addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iosd_req_t;

  typedef struct packed {
    logic       done;
    logic       refused;
    logic       skip;
    logic [7:0] rdata;
  } iosd_rsp_t;

  typedef struct packed {
    logic       impl;
    logic       pin;
    logic [1:0] pin_idx;
    logic [7:0] rw;
    logic [7:0] w1c;
  } iosd_attr_t;

  typedef logic [IOSD_NPORT-1:0][7:0] iosd_port_t;
  typedef logic [IOSD_NFLAG-1:0][7:0] iosd_evt_t;

endpackage

`default_nettype wire

/* File: iosd_io_space_decoder.sv */
// Purpose: register decode and access for the 64-location I/O space
// Assumes: one request per cycle from the core, pins asynchronous
// Notes: answer is registered and appears the cycle after the request
// What this block does
// - bit set and bit clear act only on I/O addresses 0x00 to 0x1F.
// - skip tests read one selected bit of a low register to decide.
// - bit set or clear rewrites the whole byte; flag bits read as one get cleared, except the bit a bit clear selects.
// - some flags clear on writing one; writing zero leaves them.
// - short I/O reads and writes decode exactly 64 locations.
// - each I/O register also sits in data space at its address plus 0x20.
// - extended registers above the window answer only to data-space access.
`timescale 1ns/1ps
`default_nettype none

module iosd_io_space_decoder
  import iosd_pkg::*;
#(
  parameter int EXT_DEPTH = 16
)
(
  input  wire logic       CLK_IN,
  input  wire logic       RESET_N_IN,
  input  wire iosd_req_t  REQ_IN,
  input  wire iosd_port_t PIN_LEVELS_IN,
  input  wire iosd_evt_t  FLAG_EVENTS_IN,
  output wire iosd_rsp_t  RESP_OUT,
  output wire iosd_port_t PORT_DRIVE_OUT,
  output wire iosd_port_t PORT_DIR_OUT
);

  localparam logic [IOSD_NFLAG-1:0][5:0] FLAG_LOCS = {
    IOSD_O_COMPARATOR_CTRL_STATUS,
    IOSD_O_EXT_IRQ_FLAGS,
    IOSD_O_TIMER1_FLAGS,
    IOSD_O_TIMER0_FLAGS
  };
  localparam logic [IOSD_NPORT-1:0][5:0] DRV_LOCS = {
    IOSD_O_PORT_D_OUTPUT,
    IOSD_O_PORT_C_OUTPUT,
    IOSD_O_PORT_B_OUTPUT
  };
  localparam logic [IOSD_NPORT-1:0][5:0] DIR_LOCS = {
    IOSD_O_PORT_D_DIRECTION,
    IOSD_O_PORT_C_DIRECTION,
    IOSD_O_PORT_B_DIRECTION
  };
  localparam logic [IOSD_NFLAG-1:0][7:0] FLAG_MASKS = {
    IOSD_M_CMP_W1C, IOSD_M_FULL, IOSD_M_T1_FLAGS, IOSD_M_T0_FLAGS
  };
  localparam logic [8:0] SCR0_DATA_ADDR =
    IOSD_DATA_BASE + {3'h0, IOSD_O_GENERAL_SCRATCH_0};

  typedef struct packed {
    logic [IOSD_IO_LOCS-1:0][7:0] io_mem;
    logic [EXT_DEPTH-1:0][7:0]    ext_mem;
    iosd_port_t                   pin_meta;
    iosd_port_t                   pin_sync;
    iosd_rsp_t                    rsp;
  } iosd_state_t;

  iosd_state_t state_r;
  iosd_state_t state_nxt;

  logic       wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_val;
  logic [7:0] rmw;
  logic [7:0] bit_mask;
  logic [8:0] ext_off;
  logic [8:0] io_off;
  logic       io_hit;
  logic       ext_hit;
  logic       bit_low;
  iosd_attr_t wa;

  generate
    if (EXT_DEPTH < 1 || EXT_DEPTH > 416)
    begin : g_bad_depth
      $error("EXT_DEPTH must lie in 1..416");
    end
  endgenerate

  // which bits each location keeps; reserved locations get nothing
  function automatic iosd_attr_t attr_of(input logic [5:0] a);
    iosd_attr_t t;
    t = '0;
    case (a)
      IOSD_O_PORT_B_INPUT_LEVELS:
      begin
        t.pin     = 1'b1;
        t.pin_idx = 2'd0;
      end
      IOSD_O_PORT_C_INPUT_LEVELS:
      begin
        t.pin     = 1'b1;
        t.pin_idx = 2'd1;
      end
      IOSD_O_PORT_D_INPUT_LEVELS:
      begin
        t.pin     = 1'b1;
        t.pin_idx = 2'd2;
      end
      IOSD_O_PORT_B_DIRECTION, IOSD_O_PORT_B_OUTPUT,
      IOSD_O_PORT_D_DIRECTION, IOSD_O_PORT_D_OUTPUT,
      IOSD_O_EXT_IRQ_MASK, IOSD_O_GENERAL_SCRATCH_0,
      IOSD_O_EEPROM_DATA, IOSD_O_EEPROM_ADDR_LOW,
      IOSD_O_EEPROM_ADDR_HIGH, IOSD_O_TIMER0_CONTROL_B,
      IOSD_O_TIMER0_COUNT, IOSD_O_TIMER0_COMPARE_A,
      IOSD_O_TIMER0_COMPARE_B, IOSD_O_GENERAL_SCRATCH_1,
      IOSD_O_GENERAL_SCRATCH_2, IOSD_O_SERIAL_PERIPH_CONTROL,
      IOSD_O_SERIAL_PERIPH_DATA, IOSD_O_DEBUG_LINK_DATA,
      IOSD_O_SELF_PROGRAM_CONTROL:
        t.rw = IOSD_M_FULL;
      IOSD_O_PORT_C_DIRECTION, IOSD_O_PORT_C_OUTPUT:
        t.rw = IOSD_M_PORT_C;
      IOSD_O_EEPROM_CONTROL:
        t.rw = IOSD_M_EEPROM_CTRL;
      IOSD_O_TIMER_PRESCALER_CONTROL:
        t.rw = IOSD_M_PRESCALER;
      IOSD_O_TIMER0_CONTROL_A:
        t.rw = IOSD_M_T0_CTRL_A;
      IOSD_O_PLL_CONTROL_STATUS:
        t.rw = IOSD_M_PLL_RW;
      IOSD_O_SERIAL_PERIPH_STATUS:
        t.rw = IOSD_M_SPI_STAT_RW;
      IOSD_O_COMPARATOR_CTRL_STATUS:
      begin
        t.rw  = IOSD_M_CMP_RW;
        t.w1c = IOSD_M_CMP_W1C;
      end
      IOSD_O_SLEEP_CONTROL:
        t.rw = IOSD_M_SLEEP;
      IOSD_O_RESET_CAUSE_FLAGS:
        t.rw = IOSD_M_RST_CAUSE;
      IOSD_O_VECTOR_SELECT_CONTROL:
        t.rw = IOSD_M_VEC_SEL;
      IOSD_O_TIMER0_FLAGS:
        t.w1c = IOSD_M_T0_FLAGS;
      IOSD_O_TIMER1_FLAGS:
        t.w1c = IOSD_M_T1_FLAGS;
      IOSD_O_EXT_IRQ_FLAGS:
        t.w1c = IOSD_M_FULL;
      default:
        t = '0;
    endcase
    t.impl = t.pin | (|t.rw) | (|t.w1c);
    return t;
  endfunction

  // unimplemented bits read as zero, except at pin registers, which return all eight synced pin bits
  function automatic logic [7:0] rd_io(input logic [5:0] a);
    iosd_attr_t t;
    t = attr_of(a);
    if (t.pin)
    begin
      return state_r.pin_sync[t.pin_idx];
    end
    return state_r.io_mem[a] & (t.rw | t.w1c);
  endfunction

  always_comb
  begin
    state_nxt          = state_r;
    state_nxt.pin_meta = PIN_LEVELS_IN;
    state_nxt.pin_sync = state_r.pin_meta;
    state_nxt.rsp      = '0;
    state_nxt.rsp.done = (REQ_IN.op != IOSD_OP_NONE);
    wr_en    = 1'b0;
    wr_addr  = REQ_IN.io_addr;
    wr_val   = REQ_IN.wdata;
    bit_mask = 8'h01 << REQ_IN.bit_sel;
    bit_low  = (REQ_IN.io_addr < IOSD_BIT_LIMIT);
    rmw      = rd_io(REQ_IN.io_addr);
    io_off   = REQ_IN.mem_addr - IOSD_DATA_BASE;
    ext_off  = REQ_IN.mem_addr - IOSD_EXT_BASE;
    io_hit   = (REQ_IN.mem_addr >= IOSD_DATA_BASE) &&
               (REQ_IN.mem_addr < IOSD_EXT_BASE);
    ext_hit  = (REQ_IN.mem_addr >= IOSD_EXT_BASE) &&
               (REQ_IN.mem_addr <= IOSD_EXT_TOP) &&
               (ext_off < 9'(EXT_DEPTH));
    case (REQ_IN.op)
      IOSD_IO_READ:
        state_nxt.rsp.rdata = rmw;
      IOSD_IO_WRITE:
        wr_en = 1'b1;
      IOSD_IO_BIT_SET_OP:
      begin
        // whole byte rewritten: set flags read back as one get cleared
        wr_en                 = bit_low;
        wr_val                = rmw | bit_mask;
        state_nxt.rsp.refused = !bit_low;
      end
      IOSD_IO_BIT_CLEAR_OP:
      begin
        wr_en                 = bit_low;
        wr_val                = rmw & ~bit_mask;
        state_nxt.rsp.refused = !bit_low;
      end
      IOSD_SKIP_IF_IO_BIT_SET:
      begin
        state_nxt.rsp.skip    = bit_low && (|(rmw & bit_mask));
        state_nxt.rsp.refused = !bit_low;
      end
      IOSD_SKIP_IF_IO_BIT_CLEAR:
      begin
        state_nxt.rsp.skip    = bit_low && !(|(rmw & bit_mask));
        state_nxt.rsp.refused = !bit_low;
      end
      IOSD_MEM_READ:
      begin
        if (io_hit)
        begin
          state_nxt.rsp.rdata = rd_io(io_off[5:0]);
        end
        else if (ext_hit)
        begin
          state_nxt.rsp.rdata = state_r.ext_mem[ext_off];
        end
        else
        begin
          state_nxt.rsp.refused = 1'b1;
        end
      end
      IOSD_MEM_WRITE:
      begin
        if (io_hit)
        begin
          wr_en   = 1'b1;
          wr_addr = io_off[5:0];
        end
        else if (ext_hit)
        begin
          state_nxt.ext_mem[ext_off] = REQ_IN.wdata;
        end
        else
        begin
          state_nxt.rsp.refused = 1'b1;
        end
      end
      default:
        state_nxt.rsp.done = 1'b0;
    endcase
    wa = attr_of(wr_addr);
    if (wr_en)
    begin
      // reserved locations have empty masks, so nothing moves
      state_nxt.io_mem[wr_addr] =
        (state_r.io_mem[wr_addr] & ~wa.rw) | (wr_val & wa.rw);
      state_nxt.io_mem[wr_addr] =
        state_nxt.io_mem[wr_addr] & ~(wr_val & wa.w1c);
      state_nxt.rsp.refused = !wa.impl;
    end
    // hardware set is applied last so it beats a same-cycle clear
    for (int i = 0; i < IOSD_NFLAG; i++)
    begin
      state_nxt.io_mem[FLAG_LOCS[i]] =
        state_nxt.io_mem[FLAG_LOCS[i]] |
        (FLAG_EVENTS_IN[i] & FLAG_MASKS[i]);
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign RESP_OUT = state_r.rsp;

  generate
    for (genvar p = 0; p < IOSD_NPORT; p++)
    begin : g_port
      assign PORT_DRIVE_OUT[p] = state_r.io_mem[DRV_LOCS[p]];
      assign PORT_DIR_OUT[p]   = state_r.io_mem[DIR_LOCS[p]];
    end
  endgenerate

  default clocking cb @(posedge CLK_IN);
  endclocking

  default disable iff (!RESET_N_IN);

  AST_BIT_OP_LOW_ONLY: assert property (
    (REQ_IN.op inside {IOSD_IO_BIT_SET_OP, IOSD_IO_BIT_CLEAR_OP}) &&
    (REQ_IN.io_addr >= IOSD_BIT_LIMIT)
    |=> RESP_OUT.refused && $stable(state_r.io_mem[63:32]))
    else $error("bit op above 0x1F was not refused");

  AST_SKIP_SET_BIT: assert property (
    (REQ_IN.op == IOSD_SKIP_IF_IO_BIT_SET) &&
    (REQ_IN.io_addr < IOSD_BIT_LIMIT)
    |=> RESP_OUT.skip == $past(|(rmw & bit_mask)))
    else $error("skip-if-set did not follow the bit");

  AST_SKIP_CLEAR_BIT: assert property (
    (REQ_IN.op == IOSD_SKIP_IF_IO_BIT_CLEAR) &&
    (REQ_IN.io_addr < IOSD_BIT_LIMIT)
    |=> RESP_OUT.skip != $past(|(rmw & bit_mask)))
    else $error("skip-if-clear did not follow the bit");

  AST_RMW_KEEPS_BYTE: assert property (
    (REQ_IN.op == IOSD_IO_BIT_SET_OP) &&
    (REQ_IN.io_addr == IOSD_O_GENERAL_SCRATCH_0)
    |=> state_r.io_mem[IOSD_O_GENERAL_SCRATCH_0] ==
        ($past(state_r.io_mem[IOSD_O_GENERAL_SCRATCH_0]) |
         $past(bit_mask)))
    else $error("bit set lost other bits of the byte");

  AST_RMW_CLEARS_FLAGS: assert property (
    (REQ_IN.op == IOSD_IO_BIT_SET_OP) &&
    (REQ_IN.io_addr == IOSD_O_TIMER0_FLAGS) &&
    (FLAG_EVENTS_IN[0] == 8'h00)
    |=> state_r.io_mem[IOSD_O_TIMER0_FLAGS] == 8'h00)
    else $error("bit set on flag byte left a flag standing");

  AST_W1C_ZERO_KEEPS: assert property (
    (REQ_IN.op == IOSD_IO_WRITE) &&
    (REQ_IN.io_addr == IOSD_O_TIMER0_FLAGS) &&
    (REQ_IN.wdata == 8'h00) && (FLAG_EVENTS_IN[0] == 8'h00)
    |=> $stable(state_r.io_mem[IOSD_O_TIMER0_FLAGS]))
    else $error("writing zero changed a flag");

  AST_W1C_ONE_CLEARS: assert property (
    (REQ_IN.op == IOSD_IO_WRITE) &&
    (REQ_IN.io_addr == IOSD_O_TIMER0_FLAGS) &&
    (FLAG_EVENTS_IN[0] == 8'h00)
    |=> (state_r.io_mem[IOSD_O_TIMER0_FLAGS] &
         $past(REQ_IN.wdata)) == 8'h00)
    else $error("writing one left a flag set");

  AST_IO_READ_DATA: assert property (
    (REQ_IN.op == IOSD_IO_READ) &&
    (REQ_IN.io_addr == IOSD_O_GENERAL_SCRATCH_0)
    |=> RESP_OUT.rdata ==
        $past(state_r.io_mem[IOSD_O_GENERAL_SCRATCH_0]))
    else $error("short read returned wrong data");

  AST_DATA_ALIAS: assert property (
    (REQ_IN.op == IOSD_MEM_READ) &&
    (REQ_IN.mem_addr == SCR0_DATA_ADDR)
    |=> RESP_OUT.rdata ==
        $past(state_r.io_mem[IOSD_O_GENERAL_SCRATCH_0]) &&
        !RESP_OUT.refused)
    else $error("data-space alias missed the I/O register");

  AST_EXT_DATA_WRITE: assert property (
    (REQ_IN.op == IOSD_MEM_WRITE) &&
    (REQ_IN.mem_addr == IOSD_EXT_BASE)
    |=> state_r.ext_mem[0] == $past(REQ_IN.wdata))
    else $error("extended write did not land");

  AST_RESERVED_NO_EFFECT: assert property (
    (REQ_IN.op == IOSD_IO_WRITE) && !wa.impl
    |=> RESP_OUT.refused && $stable(PORT_DRIVE_OUT) &&
        $stable(PORT_DIR_OUT))
    else $error("reserved write disturbed a register");

  AST_ONE_CYCLE: assert property (
    (REQ_IN.op != IOSD_OP_NONE) |=> RESP_OUT.done)
    else $error("access did not complete in one cycle");

  AST_NO_IDLE_DONE: assert property (
    (REQ_IN.op == IOSD_OP_NONE) |=> !RESP_OUT.done)
    else $error("done without a request");

  COV_BIT_SET_LOW: cover property (
    (REQ_IN.op == IOSD_IO_BIT_SET_OP) &&
    (REQ_IN.io_addr < IOSD_BIT_LIMIT));

  COV_SKIP_TAKEN: cover property (
    (REQ_IN.op == IOSD_SKIP_IF_IO_BIT_SET) ##1 RESP_OUT.skip);

  COV_EXT_ACCESS: cover property (
    (REQ_IN.op == IOSD_MEM_WRITE) && (REQ_IN.mem_addr >= IOSD_EXT_BASE));

  COV_FLAG_SET_AND_CLEAR: cover property (
    (REQ_IN.op == IOSD_IO_WRITE) &&
    (REQ_IN.io_addr == IOSD_O_TIMER0_FLAGS) &&
    (FLAG_EVENTS_IN[0] != 8'h00));

endmodule // iosd_io_space_decoder

`default_nettype wire

/* File: iosd_core_model.sv */
// Purpose: core-side model issuing I/O and data-space accesses
// Assumes: called at a falling edge; answer read half a cycle after the take
// Notes: every access is followed by another access or by idle
`timescale 1ns/1ps
`default_nettype none

module iosd_core_model
  import iosd_pkg::*;
(
  input  wire logic      CLK_IN,
  input  wire iosd_rsp_t RSP_IN,
  output var  iosd_req_t REQ_OUT
);

  initial REQ_OUT = '0;

  // held through the taking edge; answer read at the next falling edge
  // reserved places are reached only where a scenario asks for it
  task automatic access(input iosd_op_t op, input logic [8:0] addr,
                        input logic [2:0] b, input logic [7:0] wd,
                        output iosd_rsp_t rsp);
    REQ_OUT = '{op: op, io_addr: addr[5:0], mem_addr: addr,
                bit_sel: b, wdata: wd};
    @(posedge CLK_IN);
    @(negedge CLK_IN);
    rsp = RSP_IN;
  endtask

  // released request drops to the idle code, never left stale
  task automatic idle();
    REQ_OUT = '0;
    @(negedge CLK_IN);
  endtask

endmodule // iosd_core_model

`default_nettype wire

/* File: iosd_io_space_decoder_test.sv */
// Purpose: self-checking bench for the I/O space register decoder
// Assumes: core model drives requests at the falling edge
// Notes: random data from a fixed seed; reserved bits written as zero
`timescale 1ns/1ps
`default_nettype none

module iosd_io_space_decoder_test
  import iosd_pkg::*;
;

  localparam int EXT = 4;

  logic       clk;
  logic       rst_n;
  iosd_req_t  req;
  iosd_rsp_t  rsp;
  iosd_rsp_t  r;
  iosd_port_t pins;
  iosd_evt_t  evts;
  iosd_port_t drv;
  iosd_port_t dir;
  int         errors;
  int         checks;
  int         seed;
  logic [7:0] v;
  logic [7:0] e;
  logic [5:0] a;
  logic [7:0] shadow [0:63];
  logic [5:0] rw_a [0:13] = '{6'h04, 6'h05, 6'h07, 6'h08, 6'h0A, 6'h0B,
    6'h1D, 6'h1E, 6'h20, 6'h2A, 6'h2B, 6'h24, 6'h33, 6'h35};
  logic [8:0] bad_a [0:4] = '{9'h000, 9'h00C, 9'h039, 9'h03D, 9'h010};

  iosd_io_space_decoder #(.EXT_DEPTH(EXT)) dut_u (
    .CLK_IN         (clk),
    .RESET_N_IN     (rst_n),
    .REQ_IN         (req),
    .PIN_LEVELS_IN  (pins),
    .FLAG_EVENTS_IN (evts),
    .RESP_OUT       (rsp),
    .PORT_DRIVE_OUT (drv),
    .PORT_DIR_OUT   (dir)
  );

  iosd_core_model core_u (
    .CLK_IN  (clk),
    .RSP_IN  (rsp),
    .REQ_OUT (req)
  );

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  function automatic logic [7:0] msk(input logic [5:0] ad);
    case (ad)
      IOSD_O_PORT_C_DIRECTION, IOSD_O_PORT_C_OUTPUT,
      IOSD_O_PORT_C_INPUT_LEVELS:   msk = IOSD_M_PORT_C;
      IOSD_O_TIMER0_CONTROL_A:      msk = IOSD_M_T0_CTRL_A;
      IOSD_O_SLEEP_CONTROL:         msk = IOSD_M_SLEEP;
      IOSD_O_VECTOR_SELECT_CONTROL: msk = IOSD_M_VEC_SEL;
      default:                      msk = IOSD_M_FULL;
    endcase
  endfunction

  // byte written back by a single-bit set or clear
  function automatic logic [7:0] rmw(input logic [7:0] old,
                                     input logic [2:0] b,
                                     input logic       set);
    rmw = set ? (old | (8'h01 << b)) : (old & ~(8'h01 << b));
  endfunction

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input iosd_op_t op, input logic [8:0] ad,
                     input logic [2:0] b, input logic [7:0] wd,
                     input logic rf);
    core_u.access(op, ad, b, wd, r);
    cmp1(r.done, 1'b1);
    cmp1(r.refused, rf);
  endtask

  task automatic chk_zero();
    for (int p = 0; p < 3; p++)
    begin
      cmp8(drv[p], 8'h00);
      cmp8(dir[p], 8'h00);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // a full run is under two hundred cycles; 4000 leaves wide margin
  initial
  begin
    #100000;
    errors++;
    conclude();
  end

  initial
  begin
    errors = 0;
    checks = 0;
    seed = 10;
    rst_n = 1'b0;
    pins = '0;
    evts = '0;
    foreach (shadow[i])
      shadow[i] = 8'h00;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk_zero();
    // random data through both paths, read straight after the write
    repeat (3)
      foreach (rw_a[i])
      begin
        v = 8'($random(seed)) & msk(rw_a[i]);
        shadow[rw_a[i]] = v;
        if (seed[3])
        begin
          acc(IOSD_IO_WRITE, {3'h0, rw_a[i]}, 3'h0, v, 1'b0);
          acc(IOSD_MEM_READ, {3'h0, rw_a[i]} + IOSD_DATA_BASE, 3'h0,
              8'h00, 1'b0);
        end
        else
        begin
          acc(IOSD_MEM_WRITE, {3'h0, rw_a[i]} + IOSD_DATA_BASE, 3'h0,
              v, 1'b0);
          acc(IOSD_IO_READ, {3'h0, rw_a[i]}, 3'h0, 8'h00, 1'b0);
        end
        cmp8(r.rdata & msk(rw_a[i]), v);
      end
    for (int p = 0; p < 3; p++)
    begin
      cmp8(drv[p], shadow[6'h05 + 3 * p]);
      cmp8(dir[p], shadow[6'h04 + 3 * p]);
    end
    // pins pass two sync flops before they can be read
    pins = 24'($random(seed));
    repeat (3) core_u.idle();
    for (int p = 0; p < 3; p++)
    begin
      a = 6'(3 + 3 * p);
      acc(IOSD_IO_READ, {3'h0, a}, 3'h0, 8'h00, 1'b0);
      cmp8(r.rdata & msk(a), pins[p] & msk(a));
    end
    for (int b = 0; b < 8; b++)
    begin
      v = 8'($random(seed));
      acc(v[0] ? IOSD_IO_BIT_SET_OP : IOSD_IO_BIT_CLEAR_OP, 9'h005,
          3'(b), 8'h00, 1'b0);
      shadow[5] = rmw(shadow[5], 3'(b), v[0]);
      cmp8(drv[0], shadow[5]);
    end
    acc(IOSD_IO_BIT_SET_OP, 9'h020, 3'h1, 8'h00, 1'b1);
    acc(IOSD_SKIP_IF_IO_BIT_SET, 9'h02A, 3'h0, 8'h00, 1'b1);
    acc(IOSD_IO_READ, 9'h020, 3'h0, 8'h00, 1'b0);
    cmp8(r.rdata, shadow[6'h20]);
    for (int b = 0; b < 8; b++)
    begin
      acc(IOSD_SKIP_IF_IO_BIT_SET, 9'h01E, 3'(b), 8'h00, 1'b0);
      cmp1(r.skip, shadow[6'h1E][b]);
      acc(IOSD_SKIP_IF_IO_BIT_CLEAR, 9'h01E, 3'(b), 8'h00, 1'b0);
      cmp1(r.skip, ~shadow[6'h1E][b]);
    end
    // flags: set by events, kept by zeros, cleared by written ones
    v = 8'($random(seed)) | 8'h04;
    evts[2] = v;
    evts[0] = 8'hFF;
    evts[1] = 8'hFF;
    evts[3] = 8'hFF;
    core_u.idle();
    evts = '0;
    acc(IOSD_IO_READ, 9'h016, 3'h0, 8'h00, 1'b0);
    cmp8(r.rdata, IOSD_M_T1_FLAGS);
    acc(IOSD_IO_READ, 9'h030, 3'h0, 8'h00, 1'b0);
    cmp8(r.rdata, IOSD_M_CMP_W1C);
    acc(IOSD_IO_READ, 9'h015, 3'h0, 8'h00, 1'b0);
    cmp8(r.rdata, IOSD_M_T0_FLAGS);
    acc(IOSD_IO_WRITE, 9'h015, 3'h0, 8'h00, 1'b0);
    acc(IOSD_IO_READ, 9'h015, 3'h0, 8'h00, 1'b0);
    cmp8(r.rdata, IOSD_M_T0_FLAGS);
    // clear meeting a new event in one cycle: the event wins
    evts[0] = 8'h01;
    acc(IOSD_IO_WRITE, 9'h015, 3'h0, 8'hFF, 1'b0);
    evts = '0;
    acc(IOSD_IO_READ, 9'h015, 3'h0, 8'h00, 1'b0);
    cmp8(r.rdata, 8'h01);
    acc(IOSD_IO_BIT_SET_OP, 9'h015, 3'h1, 8'h00, 1'b0);
    acc(IOSD_IO_READ, 9'h015, 3'h0, 8'h00, 1'b0);
    cmp8(r.rdata, 8'h00);
    acc(IOSD_IO_WRITE, 9'h01C, 3'h0, 8'h00, 1'b0);
    acc(IOSD_IO_READ, 9'h01C, 3'h0, 8'h00, 1'b0);
    cmp8(r.rdata, v);
    for (int k = 0; k < 2; k++)
    begin
      e = rmw(v, 3'h2, k[0]);
      acc(k[0] ? IOSD_IO_BIT_SET_OP : IOSD_IO_BIT_CLEAR_OP, 9'h01C,
          3'h2, 8'h00, 1'b0);
      v = v & ~e;
      acc(IOSD_IO_READ, 9'h01C, 3'h0, 8'h00, 1'b0);
      cmp8(r.rdata, v);
    end
    // stray writes on purpose: refused and harmless
    foreach (bad_a[i])
      acc(i < 4 ? IOSD_IO_WRITE : IOSD_MEM_WRITE, bad_a[i], 3'h0,
          8'hFF, 1'b1);
    cmp8(drv[0], shadow[5]);
    cmp8(dir[1], shadow[7]);
    acc(IOSD_MEM_READ, 9'h03E, 3'h0, 8'h00, 1'b0);
    cmp8(r.rdata, shadow[6'h1E]);
    // extended store, one past its top refused
    for (int k = 0; k <= EXT; k++)
    begin
      v = 8'($random(seed));
      acc(IOSD_MEM_WRITE, IOSD_EXT_BASE + 9'(k), 3'h0, v, k == EXT);
      acc(IOSD_MEM_READ, IOSD_EXT_BASE + 9'(k), 3'h0, 8'h00, k == EXT);
      if (k < EXT)
        cmp8(r.rdata, v);
    end
    core_u.idle();
    cmp1(rsp.done, 1'b0);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk_zero();
    conclude();
  end

endmodule // iosd_io_space_decoder_test

`default_nettype wire
